// File: ncd_core.sv
// Datapath of the nibble core: pointer, stack, data memory and ALU
`timescale 1ns/100ps
`include "ncd_cfg.svh"

module ncd_core
    import ncd_pkg::*;
#(
    parameter int PARTITION_N = `NCD_PARTITION_DEFAULT
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // Decoded instruction
    input wire ncd_op_t I_OP,
    input wire logic I_USE_POINTER,
    input wire logic [6:0] I_DIRECT_ADDR,
    input wire logic I_SRC_IMM,
    input wire logic [3:0] I_IMM,
    input wire logic [3:0] I_WORK_SEL,
    input wire logic I_MEM_WRITEBACK,
    // Program counter exchange
    input wire logic [10:0] I_PC,
    input wire logic I_PUSH,
    input wire logic I_POP,
    output logic [10:0] O_PC_RESTORE,
    output logic O_PC_RESTORE_VALID,
    // Lookup ROM
    input wire logic [7:0] I_LOOKUP_DATA,
    output logic [11:0] O_LOOKUP_ADDR,
    output logic O_LOOKUP_IN_RANGE,
    // Datapath state
    output logic [3:0] O_ACC,
    output logic O_CARRY,
    output logic [7:0] O_POINTER_HIGH,
    output logic [3:0] O_POINTER_LOW,
    output logic O_TEST_RESULT,
    // Display decoder
    output logic [3:0] O_DISPLAY_DATA,
    output ncd_disp_mode_t O_DISPLAY_MODE,
    output logic O_DISPLAY_STROBE
);
    localparam logic [12:0] LOOKUP_BYTES = 13'(`NCD_LOOKUP_UNIT * (`NCD_PARTITION_MAX - PARTITION_N));

    if (PARTITION_N < 1 || PARTITION_N > `NCD_PARTITION_MAX) begin : g_bad_partition
        $error("PARTITION_N must lie between 1 and 9");
    end

    // ****************************************
    // Helpers
    // ****************************************
    // Returns {valid, index}; hole and unbacked space are invalid
    function automatic logic [7:0] ram_map(input logic [8:0] addr);
        logic [7:0] r;
        r = 8'h00;
        if (addr < `NCD_HOLE_LO) begin
            r = {1'b1, addr[6:0]};
        end else if (addr >= `NCD_WORK_BASE && addr <= `NCD_WORK_TOP) begin
            r = {1'b1, `NCD_WORK_INDEX | {3'h0, addr[3:0]}};
        end else if (addr >= `NCD_EXTRA_BASE && addr <= `NCD_EXTRA_TOP) begin
            r = {1'b1, `NCD_EXTRA_INDEX | {3'h0, addr[3:0]}};
        end
        return r;
    endfunction

    // Carry out is bit 4; for subtraction it means no borrow
    function automatic logic [4:0] add4(input logic [3:0] a, input logic [3:0] b, input logic cin);
        return 5'(a) + 5'(b) + 5'(cin);
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    logic [3:0] ram [`NCD_RAM_WORDS];
    logic [3:0] acc;
    logic carry;
    logic [7:0] ptr_high;
    logic [3:0] ptr_low;
    logic [10:0] stack_top;

    logic [8:0] addr;
    logic [7:0] addr_map;
    logic [7:0] work_map;
    logic [3:0] mem_rd;
    logic [3:0] work_rd;
    logic [3:0] opa;
    logic [3:0] opb;
    logic [4:0] sum;
    logic [3:0] lookup_byte_lo;
    logic [3:0] lookup_byte_hi;
    logic lookup_ok;

    logic [3:0] next_acc;
    logic next_carry;
    logic next_wr_en;
    logic next_wr_work;
    logic [3:0] next_wr_data;
    logic [7:0] wr_map;

    // ****************************************
    // Addressing
    // ****************************************
    // Pointer mode uses the low nine pointer bits
    assign addr = I_USE_POINTER ? {ptr_high[4:0], ptr_low} : {2'b00, I_DIRECT_ADDR};
    assign addr_map = ram_map(addr);
    assign work_map = ram_map(`NCD_WORK_BASE | {5'h00, I_WORK_SEL});
    assign mem_rd = addr_map[7] ? ram[addr_map[6:0]] : 4'h0;
    assign work_rd = ram[work_map[6:0]];

    // Immediate forms work on a working register, others on memory and accumulator
    assign opa = I_SRC_IMM ? work_rd : mem_rd;
    assign opb = I_SRC_IMM ? I_IMM : acc;

    // Out-of-range lookup reads return zero rather than instruction words
    assign lookup_ok = {1'b0, ptr_high, ptr_low} < LOOKUP_BYTES;
    assign lookup_byte_lo = lookup_ok ? I_LOOKUP_DATA[3:0] : 4'h0;
    assign lookup_byte_hi = lookup_ok ? I_LOOKUP_DATA[7:4] : 4'h0;

    // ****************************************
    // ALU
    // ****************************************
    always_comb begin
        next_acc = acc;
        next_carry = carry;
        next_wr_en = 1'b0;
        next_wr_work = 1'b0;
        next_wr_data = 4'h0;
        sum = 5'h00;
        unique case (I_OP)
            NCD_OP_ADD: sum = add4(opa, opb, 1'b0);
            NCD_OP_ADC: sum = add4(opa, opb, carry);
            NCD_OP_SUB: sum = add4(opa, ~opb, 1'b1);
            NCD_OP_SBC: sum = add4(opa, ~opb, carry);
            NCD_OP_INC: sum = add4(opa, 4'h0, 1'b1);
            NCD_OP_DEC: sum = add4(opa, 4'hf, 1'b0);
            NCD_OP_AND: sum = {carry, opa & opb};
            NCD_OP_XOR: sum = {carry, opa ^ opb};
            NCD_OP_OR: sum = {carry, opa | opb};
            NCD_OP_SR0: sum = {carry, 1'b0, opa[3:1]};
            NCD_OP_SR1: sum = {carry, 1'b1, opa[3:1]};
            NCD_OP_SL0: sum = {carry, opa[2:0], 1'b0};
            NCD_OP_SL1: sum = {carry, opa[2:0], 1'b1};
            NCD_OP_DECIMAL_ADJUST_ADD: begin
                sum = {carry, acc};
                if (!carry && acc > `NCD_DEC_MAX) begin
                    sum = {1'b1, acc + `NCD_DAA_FIX};
                end else if (carry && acc <= `NCD_DAA_CARRY_MAX) begin
                    sum = {1'b1, acc + `NCD_DAA_FIX};
                end
            end
            NCD_OP_DECIMAL_ADJUST_SUB: begin
                sum = {carry, acc};
                if (!carry && acc >= `NCD_DAS_LOW) begin
                    sum = {1'b0, acc + `NCD_DAS_FIX};
                end
            end
            NCD_OP_TABLE_LOW: sum = {carry, lookup_byte_lo};
            NCD_OP_TABLE_HIGH: sum = {carry, lookup_byte_hi};
            NCD_OP_LOAD_ACC: sum = {carry, opa};
            NCD_OP_SET_CARRY: sum = {1'b1, acc};
            NCD_OP_CLEAR_CARRY: sum = {1'b0, acc};
            default: sum = {carry, acc};
        endcase
        unique case (I_OP)
            NCD_OP_ADD, NCD_OP_ADC, NCD_OP_SUB, NCD_OP_SBC, NCD_OP_INC, NCD_OP_DEC,
            NCD_OP_AND, NCD_OP_XOR, NCD_OP_OR, NCD_OP_SR0, NCD_OP_SR1, NCD_OP_SL0,
            NCD_OP_SL1, NCD_OP_DECIMAL_ADJUST_ADD, NCD_OP_DECIMAL_ADJUST_SUB,
            NCD_OP_TABLE_LOW, NCD_OP_TABLE_HIGH, NCD_OP_LOAD_ACC: begin
                next_acc = sum[3:0];
                next_carry = sum[4];
                // Writeback goes to the working register in immediate forms
                next_wr_en = I_MEM_WRITEBACK;
                next_wr_work = I_SRC_IMM;
                next_wr_data = sum[3:0];
            end
            NCD_OP_SET_CARRY, NCD_OP_CLEAR_CARRY: begin
                next_carry = sum[4];
            end
            NCD_OP_MOVE_TO_WORK: begin
                next_wr_en = 1'b1;
                next_wr_work = 1'b1;
                next_wr_data = mem_rd;
            end
            NCD_OP_MOVE_FROM_WORK: begin
                next_wr_en = 1'b1;
                next_wr_data = work_rd;
            end
            default: begin
                next_acc = acc;
            end
        endcase
    end

    assign wr_map = next_wr_work ? work_map : addr_map;

    // ****************************************
    // Data memory
    // ****************************************
    // Cells are not reset; software initialises them as on the real core
    always_ff @(posedge I_CLK) begin
        if (!I_RESET && next_wr_en && wr_map[7]) begin
            ram[wr_map[6:0]] <= next_wr_data;
        end
    end

    // ****************************************
    // Accumulator and carry
    // ****************************************
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            acc <= `NCD_ACC_RESET;
            carry <= 1'b0;
        end else begin
            acc <= next_acc;
            carry <= next_carry;
        end
    end

    // ****************************************
    // Memory pointer
    // ****************************************
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            ptr_high <= `NCD_PTR_HIGH_RESET;
            ptr_low <= `NCD_PTR_LOW_RESET;
        end else if (I_OP == NCD_OP_LOAD_POINTER_LOW) begin
            ptr_low <= mem_rd;
        end else if (I_OP == NCD_OP_LOAD_POINTER_HIGH) begin
            ptr_high <= {acc, mem_rd};
        end
    end

    // ****************************************
    // Return stack
    // ****************************************
    ncd_return_stack #(
        .WIDTH(`NCD_PC_WIDTH),
        .DEPTH(`NCD_STACK_DEPTH)
    ) u_stack (
        .i_clk(I_CLK),
        .i_reset(I_RESET),
        .i_push(I_PUSH),
        .i_pop(I_POP),
        .i_push_data(I_PC),
        .o_pop_data(stack_top)
    );

    // A push in the same cycle as a pop wins, so no restore is flagged
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_PC_RESTORE <= '0;
            O_PC_RESTORE_VALID <= 1'b0;
        end else begin
            O_PC_RESTORE_VALID <= I_POP && !I_PUSH;
            if (I_POP && !I_PUSH) begin
                O_PC_RESTORE <= stack_top;
            end
        end
    end

    // ****************************************
    // Tests and display routing
    // ****************************************
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_TEST_RESULT <= 1'b0;
        end else if (I_OP == NCD_OP_TEST_BIT) begin
            O_TEST_RESULT <= mem_rd[I_IMM[1:0]];
        end else if (I_OP == NCD_OP_TEST_CARRY) begin
            O_TEST_RESULT <= carry;
        end else if (I_OP == NCD_OP_TEST_ZERO) begin
            O_TEST_RESULT <= (acc == 4'h0);
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_DISPLAY_DATA <= 4'h0;
            O_DISPLAY_MODE <= NCD_DISP_NONE;
            O_DISPLAY_STROBE <= 1'b0;
        end else begin
            O_DISPLAY_STROBE <= 1'b0;
            if (I_OP == NCD_OP_DISPLAY_DECODE || I_OP == NCD_OP_DISPLAY_BLANK_DECODE
                    || I_OP == NCD_OP_DISPLAY_PASS) begin
                O_DISPLAY_DATA <= work_rd;
                O_DISPLAY_STROBE <= 1'b1;
                O_DISPLAY_MODE <= (I_OP == NCD_OP_DISPLAY_DECODE) ? NCD_DISP_DECODE
                    : (I_OP == NCD_OP_DISPLAY_BLANK_DECODE) ? NCD_DISP_BLANK : NCD_DISP_PASS;
            end
        end
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    assign O_ACC = acc;
    assign O_CARRY = carry;
    assign O_POINTER_HIGH = ptr_high;
    assign O_POINTER_LOW = ptr_low;
    assign O_LOOKUP_ADDR = {ptr_high, ptr_low};

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_LOOKUP_IN_RANGE <= 1'b0;
        end else begin
            O_LOOKUP_IN_RANGE <= lookup_ok;
        end
    end

endmodule // ncd_core

// File: ncd_cfg.svh
// Constant macros for the nibble core datapath
`ifndef NCD_CFG_SVH
`define NCD_CFG_SVH

// ****************************************
// Widths and sizes
// ****************************************
`define NCD_PC_WIDTH 11
`define NCD_STACK_DEPTH 8
`define NCD_RAM_WORDS 96
`define NCD_LOOKUP_UNIT 256
`define NCD_PARTITION_MAX 9
`define NCD_PARTITION_DEFAULT 4

// ****************************************
// Data memory map
// ****************************************
`define NCD_HOLE_LO 9'h040
`define NCD_HOLE_HI 9'h06f
`define NCD_WORK_BASE 9'h070
`define NCD_WORK_TOP 9'h07f
`define NCD_EXTRA_BASE 9'h080
`define NCD_EXTRA_TOP 9'h08f
`define NCD_WORK_INDEX 7'h40
`define NCD_EXTRA_INDEX 7'h50

// ****************************************
// Decimal adjust constants
// ****************************************
`define NCD_DEC_MAX 4'h9
`define NCD_DAA_CARRY_MAX 4'h3
`define NCD_DAA_FIX 4'h6
`define NCD_DAS_LOW 4'h6
`define NCD_DAS_FIX 4'ha

// ****************************************
// Reset values
// ****************************************
`define NCD_ACC_RESET 4'h0
`define NCD_PTR_HIGH_RESET 8'h00
`define NCD_PTR_LOW_RESET 4'h0

`endif

// File: ncd_pkg.sv
// Types shared by the nibble core datapath
package ncd_pkg;

    // ****************************************
    // Datapath operations from the decoder
    // ****************************************
    typedef enum logic [4:0] {
        NCD_OP_NOP = 5'h00,
        NCD_OP_ADD = 5'h01,
        NCD_OP_ADC = 5'h02,
        NCD_OP_SUB = 5'h03,
        NCD_OP_SBC = 5'h04,
        NCD_OP_INC = 5'h05,
        NCD_OP_DEC = 5'h06,
        NCD_OP_AND = 5'h07,
        NCD_OP_XOR = 5'h08,
        NCD_OP_OR = 5'h09,
        NCD_OP_SR0 = 5'h0a,
        NCD_OP_SR1 = 5'h0b,
        NCD_OP_SL0 = 5'h0c,
        NCD_OP_SL1 = 5'h0d,
        NCD_OP_DECIMAL_ADJUST_ADD = 5'h0e,
        NCD_OP_DECIMAL_ADJUST_SUB = 5'h0f,
        NCD_OP_LOAD_POINTER_LOW = 5'h10,
        NCD_OP_LOAD_POINTER_HIGH = 5'h11,
        NCD_OP_MOVE_TO_WORK = 5'h12,
        NCD_OP_MOVE_FROM_WORK = 5'h13,
        NCD_OP_DISPLAY_DECODE = 5'h14,
        NCD_OP_DISPLAY_BLANK_DECODE = 5'h15,
        NCD_OP_DISPLAY_PASS = 5'h16,
        NCD_OP_TABLE_LOW = 5'h17,
        NCD_OP_TABLE_HIGH = 5'h18,
        NCD_OP_TEST_BIT = 5'h19,
        NCD_OP_TEST_CARRY = 5'h1a,
        NCD_OP_TEST_ZERO = 5'h1b,
        NCD_OP_LOAD_ACC = 5'h1c,
        NCD_OP_SET_CARRY = 5'h1d,
        NCD_OP_CLEAR_CARRY = 5'h1e
    } ncd_op_t;

    // ****************************************
    // Display routing mode
    // ****************************************
    typedef enum logic [1:0] {
        NCD_DISP_NONE = 2'h0,
        NCD_DISP_DECODE = 2'h1,
        NCD_DISP_BLANK = 2'h2,
        NCD_DISP_PASS = 2'h3
    } ncd_disp_mode_t;

endpackage

// File: ncd_return_stack.sv
// Eight level return stack with wrap on overflow and underflow
`timescale 1ns/100ps
`include "ncd_cfg.svh"

module ncd_return_stack #(
    parameter int WIDTH = `NCD_PC_WIDTH,
    parameter int DEPTH = `NCD_STACK_DEPTH
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Requests
    input wire logic i_push,
    input wire logic i_pop,
    input wire logic [WIDTH-1:0] i_push_data,
    // Entry under the pointer
    output logic [WIDTH-1:0] o_pop_data
);
    localparam int SPW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << SPW) != DEPTH) begin : g_bad_depth
        $error("Stack depth must be a power of two");
    end

    logic [WIDTH-1:0] entry [DEPTH];
    logic [SPW-1:0] level;
    logic [SPW-1:0] next_push_level;

    // Pointer starts on the last level so the first push lands on level 0
    assign next_push_level = level + SPW'(1);
    assign o_pop_data = entry[level];

    // ****************************************
    // Pointer, wrapping with no overflow flag
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            level <= SPW'(DEPTH - 1);
        end else if (i_push) begin
            level <= next_push_level;
        end else if (i_pop) begin
            level <= level - SPW'(1);
        end
    end

    // ****************************************
    // Storage
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            for (int i = 0; i < DEPTH; i++) begin
                entry[i] <= '0;
            end
        end else if (i_push) begin
            // A ninth push overwrites level 0
            entry[next_push_level] <= i_push_data;
        end
    end

endmodule // ncd_return_stack

// File: ncd_core_asserts.sv
// Assertion checker bound to the nibble core datapath
`timescale 1ns/100ps
module ncd_core_asserts
    import ncd_pkg::*;
#(
    parameter int PARTITION_N = 4
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // Requests
    input wire ncd_op_t I_OP,
    input wire logic I_PUSH,
    input wire logic I_POP,
    // Watched state
    input wire logic O_PC_RESTORE_VALID,
    input wire logic [11:0] O_LOOKUP_ADDR,
    input wire logic O_LOOKUP_IN_RANGE,
    input wire logic [3:0] O_ACC,
    input wire logic O_CARRY,
    input wire logic [7:0] O_POINTER_HIGH,
    input wire logic [3:0] O_POINTER_LOW,
    input wire ncd_disp_mode_t O_DISPLAY_MODE,
    input wire logic O_DISPLAY_STROBE
);
    localparam int LIMIT = 256 * (9 - PARTITION_N);

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RESET);

    // ****************************************
    // Stack, pointer and lookup
    // ****************************************
    a_pop_gives_valid: assert property (I_POP && !I_PUSH |=> O_PC_RESTORE_VALID)
        else $error("Pop not answered by a restore pulse");
    a_valid_needs_pop: assert property (!I_POP |=> !O_PC_RESTORE_VALID)
        else $error("Restore pulse without a pop");
    a_lookup_is_ptr: assert property (O_LOOKUP_ADDR == {O_POINTER_HIGH, O_POINTER_LOW})
        else $error("Lookup address differs from pointer");
    a_ptr_high_load: assert property (I_OP == NCD_OP_LOAD_POINTER_HIGH |=>
        O_POINTER_HIGH[7:4] == $past(O_ACC) && $stable(O_POINTER_LOW))
        else $error("Pointer high load wrong");
    a_ptr_holds: assert property (!(I_OP inside {NCD_OP_LOAD_POINTER_LOW, NCD_OP_LOAD_POINTER_HIGH}) |=>
        $stable({O_POINTER_HIGH, O_POINTER_LOW}))
        else $error("Pointer changed without a load");
    a_range_flag: assert property (!$past(I_RESET) |-> O_LOOKUP_IN_RANGE == ($past(O_LOOKUP_ADDR) < LIMIT))
        else $error("Lookup range flag wrong");

    // ****************************************
    // ALU and display
    // ****************************************
    a_daa_high: assert property (I_OP == NCD_OP_DECIMAL_ADJUST_ADD && O_ACC > 4'h9 && !O_CARRY |=>
        O_ACC == $past(O_ACC) + 4'h6 && O_CARRY)
        else $error("Decimal adjust after add wrong");
    a_das_fix: assert property (I_OP == NCD_OP_DECIMAL_ADJUST_SUB && O_ACC > 4'h5 && !O_CARRY |=>
        O_ACC == $past(O_ACC) + 4'ha && !O_CARRY)
        else $error("Decimal adjust after subtract wrong");
    a_logic_carry: assert property (I_OP inside {[NCD_OP_AND:NCD_OP_SL1]} |=> $stable(O_CARRY))
        else $error("Logic or shift changed carry");
    a_display_pass: assert property (I_OP == NCD_OP_DISPLAY_PASS |=>
        O_DISPLAY_STROBE && O_DISPLAY_MODE == NCD_DISP_PASS)
        else $error("Display pass not routed");
    a_strobe_cause: assert property (O_DISPLAY_STROBE |->
        $past(I_OP) inside {[NCD_OP_DISPLAY_DECODE:NCD_OP_DISPLAY_PASS]})
        else $error("Display strobe without display op");
endmodule // ncd_core_asserts

bind ncd_core ncd_core_asserts #(.PARTITION_N(PARTITION_N)) u_ncd_asserts (
    .I_CLK(I_CLK),
    .I_RESET(I_RESET),
    .I_OP(I_OP),
    .I_PUSH(I_PUSH),
    .I_POP(I_POP),
    .O_PC_RESTORE_VALID(O_PC_RESTORE_VALID),
    .O_LOOKUP_ADDR(O_LOOKUP_ADDR),
    .O_LOOKUP_IN_RANGE(O_LOOKUP_IN_RANGE),
    .O_ACC(O_ACC),
    .O_CARRY(O_CARRY),
    .O_POINTER_HIGH(O_POINTER_HIGH),
    .O_POINTER_LOW(O_POINTER_LOW),
    .O_DISPLAY_MODE(O_DISPLAY_MODE),
    .O_DISPLAY_STROBE(O_DISPLAY_STROBE)
);

// File: ncd_seq_model.sv
// Sequencer and shared code memory model facing the datapath
`timescale 1ns/100ps
module ncd_seq_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Program counter exchange
    input wire logic [10:0] i_pc_restore,
    input wire logic i_pc_restore_valid,
    output logic [10:0] o_pc,
    // Lookup memory
    input wire logic [11:0] i_lookup_addr,
    output logic [7:0] o_lookup_data
);
    // Code words show through past the table area, zero only when bits 3:0 are 5 and bits 7:4 match bits 11:8
    assign o_lookup_data = i_lookup_addr[7:0] ^ {i_lookup_addr[11:8], 4'h5};

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_pc <= 11'h000;
        end else if (i_pc_restore_valid) begin
            o_pc <= i_pc_restore;
        end else begin
            o_pc <= o_pc + 11'h001;
        end
    end
endmodule // ncd_seq_model

// File: tb.sv
// Self-checking testbench for the nibble core datapath
`timescale 1ns/100ps
module tb;
    import ncd_pkg::*;
    localparam int LIMIT = 256 * (9 - 4);
    logic clk, rst, use_ptr, src_imm, wb, push, pop, pc_vld, in_rng, carry, strobe, tst;
    ncd_op_t op;
    ncd_disp_mode_t dmode;
    logic [6:0] daddr;
    logic [3:0] imm, wsel, acc, pl, ddata;
    logic [10:0] pc, pc_rst;
    logic [11:0] laddr, ptr_m;
    logic [7:0] ldata, ph, lk;
    logic [3:0] mem [0:511];
    logic [10:0] stk [0:7];
    logic [11:0] ptrs [6] = '{12'h085, 12'h1a0, 12'h052, 12'h075, 12'h4ff, 12'h500};
    logic [2:0] sp_m;
    logic [4:0] r;
    int miscompares, cmp_count, cycles;
    int seed = 32'h3101f71a;

    ncd_core #(.PARTITION_N(4)) u_dut (
        .I_CLK(clk), .I_RESET(rst), .I_OP(op), .I_USE_POINTER(use_ptr),
        .I_DIRECT_ADDR(daddr), .I_SRC_IMM(src_imm), .I_IMM(imm), .I_WORK_SEL(wsel),
        .I_MEM_WRITEBACK(wb), .I_PC(pc), .I_PUSH(push), .I_POP(pop),
        .O_PC_RESTORE(pc_rst), .O_PC_RESTORE_VALID(pc_vld), .I_LOOKUP_DATA(ldata),
        .O_LOOKUP_ADDR(laddr), .O_LOOKUP_IN_RANGE(in_rng), .O_ACC(acc), .O_CARRY(carry),
        .O_POINTER_HIGH(ph), .O_POINTER_LOW(pl), .O_TEST_RESULT(tst),
        .O_DISPLAY_DATA(ddata), .O_DISPLAY_MODE(dmode), .O_DISPLAY_STROBE(strobe)
    );
    ncd_seq_model u_seq (
        .i_clk(clk), .i_reset(rst), .i_pc_restore(pc_rst), .i_pc_restore_valid(pc_vld),
        .o_pc(pc), .i_lookup_addr(laddr), .o_lookup_data(ldata)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ****************************************
    // Expectations and bus tasks
    // ****************************************
    function automatic logic reach(input logic [8:0] a);
        return !(a inside {[9'h040:9'h06f]}) && a < 9'h090;
    endfunction
    function automatic logic [7:0] rom(input logic [11:0] p);
        return p < LIMIT ? p[7:0] ^ {p[11:8], 4'h5} : 8'h00;
    endfunction
    function automatic logic [4:0] alu(input ncd_op_t o, input logic [3:0] a, b, input logic c);
        case (o)
            NCD_OP_ADD: return {1'b0, a} + {1'b0, b};
            NCD_OP_ADC: return {1'b0, a} + {1'b0, b} + {4'h0, c};
            NCD_OP_SUB: return {1'b0, a} + {1'b0, ~b} + 5'h01;
            NCD_OP_SBC: return {1'b0, a} + {1'b0, ~b} + {4'h0, c};
            NCD_OP_INC: return {1'b0, a} + 5'h01;
            NCD_OP_DEC: return {a != 4'h0, a - 4'h1};
            NCD_OP_AND: return {c, a & b};
            NCD_OP_XOR: return {c, a ^ b};
            NCD_OP_OR: return {c, a | b};
            NCD_OP_SR0: return {c, 1'b0, a[3:1]};
            NCD_OP_SR1: return {c, 1'b1, a[3:1]};
            NCD_OP_SL0: return {c, a[2:0], 1'b0};
            NCD_OP_SL1: return {c, a[2:0], 1'b1};
            NCD_OP_DECIMAL_ADJUST_ADD: return (b > 4'h9 && !c) || (b < 4'h4 && c) ? {1'b1, b + 4'h6} : {c, b};
            NCD_OP_DECIMAL_ADJUST_SUB: return b > 4'h5 && !c ? {c, b + 4'ha} : {c, b};
            default: return {c, b};
        endcase
    endfunction
    task automatic check(input string what, input logic [19:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Op is left applied; every edge that follows is another step
    task automatic step(input ncd_op_t o, input logic p, input logic [6:0] d, input logic si, w);
        op = o;
        use_ptr = p;
        daddr = d;
        src_imm = si;
        wb = w;
        @(posedge clk);
        #2;
    endtask
    task automatic set_work(input logic [3:0] n, v);
        wsel = n;
        imm = 4'h0;
        step(NCD_OP_AND, 1'b0, 7'h00, 1'b1, 1'b1);
        imm = v;
        step(NCD_OP_OR, 1'b0, 7'h00, 1'b1, 1'b1);
        mem[{5'h07, n}] = v;
    endtask
    task automatic wr_direct(input logic [6:0] d, input logic [3:0] v);
        set_work(4'h1, v);
        step(NCD_OP_MOVE_FROM_WORK, 1'b0, d, 1'b0, 1'b0);
        if (reach({2'b00, d})) mem[d] = v;
    endtask
    task automatic rd_chk(input logic p, input logic [6:0] d);
        logic [8:0] a;
        a = p ? ptr_m[8:0] : {2'b00, d};
        set_work(4'hf, 4'h0);
        step(NCD_OP_OR, p, d, 1'b0, 1'b0);
        check("memory", acc, reach(a) ? mem[a] : 4'h0);
    endtask
    task automatic set_ptr(input logic [11:0] v);
        wr_direct(7'h00, v[3:0]);
        step(NCD_OP_LOAD_POINTER_LOW, 1'b0, 7'h00, 1'b0, 1'b0);
        check("pointer low", pl, v[3:0]);
        wr_direct(7'h01, v[7:4]);
        set_work(4'h2, v[11:8]);
        step(NCD_OP_LOAD_POINTER_HIGH, 1'b0, 7'h01, 1'b0, 1'b0);
        ptr_m = v;
        check("pointer", {ph, pl}, v);
    endtask
    task automatic wr_ptr(input logic [3:0] v);
        set_work(4'hf, 4'h0);
        step(NCD_OP_AND, 1'b1, 7'h00, 1'b0, 1'b1);
        set_work(4'hf, v);
        step(NCD_OP_OR, 1'b1, 7'h00, 1'b0, 1'b1);
        if (reach(ptr_m[8:0])) mem[ptr_m[8:0]] = v;
    endtask
    task automatic alu_case(input ncd_op_t o, input logic [3:0] a, b, input logic c);
        wr_direct(7'h10, a);
        set_work(4'h3, b);
        step(c ? NCD_OP_SET_CARRY : NCD_OP_CLEAR_CARRY, 1'b0, 7'h10, 1'b0, 1'b0);
        step(o, 1'b0, 7'h10, 1'b0, 1'b1);
        r = alu(o, a, b, c);
        mem[7'h10] = r[3:0];
        check("acc", acc, r[3:0]);
        check("carry", carry, r[4]);
        step(NCD_OP_MOVE_TO_WORK, 1'b0, 7'h10, 1'b0, 1'b0);
        mem[7'h73] = r[3:0];
        step(NCD_OP_TEST_BIT, 1'b0, 7'h73, 1'b0, 1'b0);
        check("test bit", tst, r[b[1:0]]);
        step(NCD_OP_TEST_CARRY, 1'b0, 7'h10, 1'b0, 1'b0);
        check("test carry", tst, r[4]);
        rd_chk(1'b0, 7'h10);
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            miscompares++;
            conclude();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {rst, use_ptr, src_imm, wb, push, pop} = 6'b100000;
        op = NCD_OP_NOP;
        {daddr, imm, wsel} = 15'h0000;
        repeat (5) @(posedge clk);
        #2;
        check("reset state", {ph, pl, acc, carry, pc_vld, dmode}, 20'h00000);
        rst = 1'b0;
        for (int i = 0; i < 128; i++) begin
            if (reach(9'(i))) wr_direct(7'(i), 4'($random(seed)));
        end
        for (int i = 0; i < 24; i++) rd_chk(1'b0, 7'($random(seed)));
        wr_direct(7'h45, 4'ha);
        rd_chk(1'b0, 7'h45);
        foreach (ptrs[i]) begin
            set_ptr(ptrs[i]);
            wr_ptr(4'($random(seed)));
            rd_chk(1'b1, 7'h00);
            check("in range", in_rng, ptrs[i] < LIMIT);
            lk = rom(ptrs[i]);
            step(NCD_OP_TABLE_LOW, 1'b0, 7'h00, 1'b0, 1'b0);
            check("table low", acc, lk[3:0]);
            step(NCD_OP_TABLE_HIGH, 1'b0, 7'h00, 1'b0, 1'b0);
            check("table high", acc, lk[7:4]);
        end
        for (int m = 1; m < 4; m++) begin
            wsel = 4'h5;
            step(ncd_op_t'(5'h13 + 5'(m)), 1'b0, 7'h00, 1'b0, 1'b0);
            check("display", {strobe, dmode, ddata}, {1'b1, 2'(m), mem[9'h075]});
        end
        for (int i = 0; i < 48; i++) begin
            alu_case(ncd_op_t'(5'(1 + $unsigned($random(seed)) % 15)), 4'($random(seed)), 4'($random(seed)),
                1'($random(seed)));
        end
        for (int v = 0; v < 32; v++) begin
            alu_case(NCD_OP_DECIMAL_ADJUST_ADD, 4'($random(seed)), 4'(v), v[4]);
            alu_case(NCD_OP_DECIMAL_ADJUST_SUB, 4'($random(seed)), 4'(v), v[4]);
        end
        step(NCD_OP_NOP, 1'b0, 7'h00, 1'b0, 1'b0);
        check("strobe", strobe, 1'b0);
        // Nine pushes from reset overflow onto level 0, eleven pops underflow
        foreach (stk[i]) stk[i] = 11'h000;
        sp_m = 3'd7;
        push = 1'b1;
        for (int i = 0; i < 9; i++) begin
            sp_m = sp_m + 3'd1;
            stk[sp_m] = pc;
            @(posedge clk);
            #2;
        end
        push = 1'b0;
        pop = 1'b1;
        for (int i = 0; i < 11; i++) begin
            @(posedge clk);
            #2;
            check("restore", {pc_vld, pc_rst}, {1'b1, stk[sp_m]});
            sp_m = sp_m - 3'd1;
        end
        pop = 1'b0;
        @(posedge clk);
        #2;
        check("restore pulse", pc_vld, 1'b0);
        conclude();
    end
endmodule // tb
